/* hdl/ssk_pkg.sv */
// constants and encodings for the serial start and clocking logic
package ssk_pkg;
  localparam int DATA_LEN_DEF = 8;
  localparam int DLY_W_DEF = 8;
  localparam int DIV_W_DEF = 12;
  localparam int SEL_W = 3;
  // start selection
  localparam logic [2:0] START_CONT = 3'h0;
  localparam logic [2:0] START_RX = 3'h1;
  localparam logic [2:0] START_LOW = 3'h2;
  localparam logic [2:0] START_HIGH = 3'h3;
  localparam logic [2:0] START_FALL = 3'h4;
  localparam logic [2:0] START_RISE = 3'h5;
  localparam logic [2:0] START_LEVEL = 3'h6;
  localparam logic [2:0] START_ANY = 3'h7;
  // frame sync output select
  localparam logic [2:0] FS_NONE = 3'h0;
  localparam logic [2:0] FS_NEG_PULSE = 3'h1;
  localparam logic [2:0] FS_POS_PULSE = 3'h2;
  localparam logic [2:0] FS_LOW = 3'h3;
  localparam logic [2:0] FS_HIGH = 3'h4;
  localparam logic [2:0] FS_TOGGLE = 3'h5;
  // clock source select
  localparam logic [1:0] CKS_DIV = 2'h0;
  localparam logic [1:0] CKS_OWN_PIN = 2'h1;
  localparam logic [1:0] CKS_OTHER = 2'h2;
  // clock output mode
  localparam logic [1:0] CKO_NONE = 2'h0;
  localparam logic [1:0] CKO_CONT = 2'h1;
  localparam logic [1:0] CKO_XFER = 2'h2;
  // extra lag of an rx-triggered tx start
  localparam int START_LAG = 2;
  // reset values
  localparam logic RST_LEVEL = 1'b0;
  localparam logic RST_FS_LEVEL = 1'b1;
endpackage : ssk_pkg

/* hdl/ssk_clk_div.sv */
// master clock divider for the serial clock
`timescale 1ns/1ps
module ssk_clk_div #(
  parameter int DIV_W = 12
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic en,
  input wire logic [DIV_W-1:0] divVal,
  // divided clock
  output logic clkLevel_q,
  output logic risePulse,
  output logic fallPulse
);
  import ssk_pkg::*;

  logic [DIV_W:0] cnt_q, cnt_d;
  logic first_q, first_d;
  logic clkLevel_d;
  logic [DIV_W:0] half;
  logic wrap;

  initial begin
    if (DIV_W < 1) $error("ssk_clk_div: DIV_W must be at least 1");
  end

  always_comb begin
    half = first_q ? ({1'b0, divVal} + {{DIV_W{1'b0}}, 1'b1}) : {1'b0, divVal};
    wrap = en && (cnt_q + {{DIV_W{1'b0}}, 1'b1} >= half);
    cnt_d = cnt_q;
    first_d = first_q;
    clkLevel_d = clkLevel_q;
    if (!en) begin
      cnt_d = '0;
      first_d = 1'b1;
      clkLevel_d = RST_LEVEL;
    end else if (wrap) begin
      cnt_d = '0;
      clkLevel_d = !clkLevel_q;
      if (clkLevel_q) first_d = 1'b0;
    end else begin
      cnt_d = cnt_q + {{DIV_W{1'b0}}, 1'b1};
    end
    risePulse = wrap && !clkLevel_q;
    fallPulse = wrap && clkLevel_q;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      first_q <= 1'b1;
      clkLevel_q <= RST_LEVEL;
    end else begin
      cnt_q <= cnt_d;
      first_q <= first_d;
      clkLevel_q <= clkLevel_d;
    end
  end
endmodule : ssk_clk_div

/* hdl/ssk_start_clocking.sv */
// start, frame-sync and clock output logic of the serial controller
`timescale 1ns/1ps
module ssk_start_clocking #(
  parameter int DATA_LEN = ssk_pkg::DATA_LEN_DEF,
  parameter int DLY_W = ssk_pkg::DLY_W_DEF,
  parameter int DIV_W = ssk_pkg::DIV_W_DEF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // shared configuration
  input wire logic [DIV_W-1:0] clkDiv,
  // transmit configuration
  input wire logic [ssk_pkg::SEL_W-1:0] txStartSel,
  input wire logic [DLY_W-1:0] txStartDelay,
  input wire logic [ssk_pkg::SEL_W-1:0] txFsOutSel,
  input wire logic [1:0] txClkSource,
  input wire logic txClkIsOutput,
  input wire logic [DATA_LEN-1:0] txWord,
  // receive configuration
  input wire logic [ssk_pkg::SEL_W-1:0] rxStartSel,
  input wire logic [ssk_pkg::SEL_W-1:0] rxFsOutSel,
  input wire logic [1:0] rxClkSource,
  input wire logic [1:0] rxClkOutMode,
  input wire logic rxClkInvert,
  // transmit pins
  input wire logic txClkIn,
  output logic txClkOut_q,
  output logic txClkOe_q,
  input wire logic txFsIn,
  output logic txFsOut_q,
  output logic txFsOe_q,
  output logic txDataOut_q,
  output logic txDataOe_q,
  // receive pins
  input wire logic rxClkIn,
  output logic rxClkOut_q,
  output logic rxClkOe_q,
  input wire logic rxFsIn,
  input wire logic rxDataIn,
  // status
  output logic txDone_q,
  output logic txReject_q,
  output logic [DATA_LEN-1:0] rxWord_q,
  output logic rxValid_q
);
  import ssk_pkg::*;

  typedef enum logic [1:0] {TX_IDLE, TX_DELAY, TX_SHIFT} ssk_tx_e;
  typedef enum logic {RX_IDLE, RX_RECV} ssk_rx_e;
  localparam int CNT_W = (DLY_W > $clog2(DATA_LEN + 1)) ? DLY_W : $clog2(DATA_LEN + 1);
  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(DATA_LEN - 1);

  initial begin
    if (DATA_LEN < 1 || DLY_W < 1 || DIV_W < 1) $error("ssk_start_clocking: widths must be at least 1");
  end

  function automatic logic startHit(input logic [SEL_W-1:0] sel, input logic cur, input logic prev);
    case (sel)
      START_LOW: startHit = !cur;
      START_HIGH: startHit = cur;
      START_FALL: startHit = prev && !cur;
      START_RISE: startHit = !prev && cur;
      START_LEVEL, START_ANY: startHit = prev != cur;
      default: startHit = 1'b0;
    endcase
  endfunction : startHit

  function automatic logic isEdgeSel(input logic [SEL_W-1:0] sel);
    isEdgeSel = (sel == START_FALL) || (sel == START_RISE) || (sel == START_ANY);
  endfunction : isEdgeSel

  // divided clock
  logic divRun, divLevel, divRise, divFall;
  ssk_tx_e txState_q, txState_d;
  ssk_rx_e rxState_q, rxState_d;
  logic [CNT_W-1:0] txCnt_q, txCnt_d, rxCnt_q, rxCnt_d;
  logic [DATA_LEN-1:0] txShift_q, txShift_d, rxWord_d, rxShift_q, rxShift_d;
  logic [START_LAG-1:0] rxStartLag_q, rxStartLag_d;
  logic txFsPrev_q, rxFsPrev_q, txClkPrev_q, rxClkPrev_q;
  logic txClkOut_d, txClkOe_d, txFsOut_d, txFsOe_d, txDataOut_d, txDataOe_d;
  logic rxClkOut_d, rxClkOe_d, txDone_d, txReject_d, rxValid_d, toggle_q, toggle_d, firstBit_q, firstBit_d;
  logic rxStartEv, txStartEv, txBlocked, useLag, rxUsesDiv, rxRise, rxFall, rxSample, txFall;

  always_comb begin
    rxUsesDiv = (rxClkSource == CKS_DIV) && (clkDiv != '0);
    divRun = (clkDiv != '0) && ((rxClkOutMode != CKO_XFER) || (rxState_q == RX_RECV) || rxStartEv);
  end

  ssk_clk_div #(.DIV_W(DIV_W)) divider (
    .ref_clk(ref_clk),
    .rst(rst),
    .en(divRun),
    .divVal(clkDiv),
    .clkLevel_q(divLevel),
    .risePulse(divRise),
    .fallPulse(divFall)
  );

  // start detection and clock selection
  always_comb begin
    rxRise = rxUsesDiv ? divRise : (!rxClkPrev_q && rxClkIn);
    rxFall = rxUsesDiv ? divFall : (rxClkPrev_q && !rxClkIn);
    rxSample = rxClkInvert ? rxRise : rxFall;
    case (txClkSource)
      CKS_OWN_PIN: txFall = txClkPrev_q && !txClkIn;
      CKS_OTHER: txFall = rxFall;
      default: txFall = divFall;
    endcase
    rxStartEv = (rxState_q == RX_IDLE) && ((rxStartSel == START_CONT) ||
      ((rxFsOutSel == FS_NONE) && startHit(rxStartSel, rxFsIn, rxFsPrev_q)));
    useLag = (txStartSel == START_RX) && (txStartDelay != '0) && isEdgeSel(rxStartSel) && (rxFsOutSel == FS_NONE);
    rxStartLag_d = {rxStartLag_q[START_LAG-2:0], rxStartEv};
    txBlocked = txClkIsOutput && (txFsOutSel == FS_NONE) && isEdgeSel(txStartSel) &&
      (txStartDelay == '0);
    case (txStartSel)
      START_CONT: txStartEv = 1'b1;
      START_RX: txStartEv = useLag ? rxStartLag_q[START_LAG-1] : rxStartEv;
      default: txStartEv = (txFsOutSel == FS_NONE) && startHit(txStartSel, txFsIn, txFsPrev_q) && !txBlocked;
    endcase
  end

  // transmit sequencing
  always_comb begin
    txState_d = txState_q;
    txCnt_d = txCnt_q;
    txShift_d = txShift_q;
    txDataOut_d = txDataOut_q;
    txDataOe_d = txDataOe_q;
    toggle_d = toggle_q;
    firstBit_d = firstBit_q;
    txDone_d = 1'b0;
    txReject_d = txBlocked;
    case (txState_q)
      TX_IDLE: begin
        if (txStartEv) begin
          if (txFsOutSel == FS_TOGGLE) toggle_d = !toggle_q;
          if (txStartDelay == '0) begin
            txState_d = TX_SHIFT;
            txShift_d = txWord << 1;
            txDataOut_d = txWord[DATA_LEN-1];
            txDataOe_d = 1'b1;
            txCnt_d = LAST_BIT;
            firstBit_d = 1'b1;
          end else begin
            txState_d = TX_DELAY;
            txCnt_d = CNT_W'(txStartDelay);
          end
        end
      end
      TX_DELAY: begin
        if (txFall) begin
          if (txCnt_q == CNT_W'(1)) begin
            txState_d = TX_SHIFT;
            txShift_d = txWord << 1;
            txDataOut_d = txWord[DATA_LEN-1];
            txDataOe_d = 1'b1;
            txCnt_d = LAST_BIT;
            firstBit_d = 1'b1;
          end else begin
            txCnt_d = txCnt_q - CNT_W'(1);
          end
        end
      end
      TX_SHIFT: begin
        if (txFall) begin
          firstBit_d = 1'b0;
          if (txCnt_q == '0) begin
            txState_d = TX_IDLE;
            txDataOe_d = 1'b0;
            txDone_d = 1'b1;
          end else begin
            txDataOut_d = txShift_q[DATA_LEN-1];
            txShift_d = txShift_q << 1;
            txCnt_d = txCnt_q - CNT_W'(1);
          end
        end
      end
      default: txState_d = TX_IDLE;
    endcase
    // frame sync output
    txFsOe_d = txFsOutSel != FS_NONE;
    case (txFsOutSel)
      FS_NEG_PULSE: txFsOut_d = !(txState_d == TX_SHIFT && firstBit_d);
      FS_POS_PULSE: txFsOut_d = txState_d == TX_SHIFT && firstBit_d;
      FS_LOW: txFsOut_d = txState_d == TX_IDLE;
      FS_HIGH: txFsOut_d = txState_d != TX_IDLE;
      FS_TOGGLE: txFsOut_d = toggle_d;
      default: txFsOut_d = RST_FS_LEVEL;
    endcase
    txClkOut_d = divLevel;
    txClkOe_d = txClkIsOutput;
  end

  // receive sequencing and clock output
  always_comb begin
    rxState_d = rxState_q;
    rxCnt_d = rxCnt_q;
    rxShift_d = rxShift_q;
    rxWord_d = rxWord_q;
    rxValid_d = 1'b0;
    case (rxState_q)
      RX_IDLE: begin
        if (rxStartEv) begin
          rxState_d = RX_RECV;
          rxCnt_d = LAST_BIT;
        end
      end
      RX_RECV: begin
        if (rxSample) begin
          rxShift_d = {rxShift_q[DATA_LEN-2:0], rxDataIn};
          if (rxCnt_q == '0) begin
            rxState_d = RX_IDLE;
            rxWord_d = {rxShift_q[DATA_LEN-2:0], rxDataIn};
            rxValid_d = 1'b1;
          end else begin
            rxCnt_d = rxCnt_q - CNT_W'(1);
          end
        end
      end
      default: rxState_d = RX_IDLE;
    endcase
    rxClkOut_d = divLevel ^ rxClkInvert;
    case (rxClkOutMode)
      CKO_CONT: rxClkOe_d = 1'b1;
      CKO_XFER: rxClkOe_d = rxState_d == RX_RECV;
      default: rxClkOe_d = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      txState_q <= TX_IDLE;
      rxState_q <= RX_IDLE;
      txCnt_q <= '0;
      rxCnt_q <= '0;
      txShift_q <= '0;
      rxShift_q <= '0;
      rxWord_q <= '0;
      rxStartLag_q <= '0;
      txFsPrev_q <= RST_LEVEL;
      rxFsPrev_q <= RST_LEVEL;
      txClkPrev_q <= RST_LEVEL;
      rxClkPrev_q <= RST_LEVEL;
      toggle_q <= RST_LEVEL;
      firstBit_q <= 1'b0;
      txClkOut_q <= RST_LEVEL;
      txClkOe_q <= 1'b0;
      txFsOut_q <= RST_FS_LEVEL;
      txFsOe_q <= 1'b0;
      txDataOut_q <= RST_LEVEL;
      txDataOe_q <= 1'b0;
      rxClkOut_q <= RST_LEVEL;
      rxClkOe_q <= 1'b0;
      txDone_q <= 1'b0;
      txReject_q <= 1'b0;
      rxValid_q <= 1'b0;
    end else begin
      txState_q <= txState_d;
      rxState_q <= rxState_d;
      txCnt_q <= txCnt_d;
      rxCnt_q <= rxCnt_d;
      txShift_q <= txShift_d;
      rxShift_q <= rxShift_d;
      rxWord_q <= rxWord_d;
      rxStartLag_q <= rxStartLag_d;
      txFsPrev_q <= txFsIn;
      rxFsPrev_q <= rxFsIn;
      txClkPrev_q <= txClkIn;
      rxClkPrev_q <= rxClkIn;
      toggle_q <= toggle_d;
      firstBit_q <= firstBit_d;
      txClkOut_q <= txClkOut_d;
      txClkOe_q <= txClkOe_d;
      txFsOut_q <= txFsOut_d;
      txFsOe_q <= txFsOe_d;
      txDataOut_q <= txDataOut_d;
      txDataOe_q <= txDataOe_d;
      rxClkOut_q <= rxClkOut_d;
      rxClkOe_q <= rxClkOe_d;
      txDone_q <= txDone_d;
      txReject_q <= txReject_d;
      rxValid_q <= rxValid_d;
    end
  end
endmodule : ssk_start_clocking

/* test/ssk_start_clocking_checker.sv */
// port assertions for the serial start and clocking logic
`timescale 1ns/1ps
module ssk_start_clocking_checker #(
  parameter int DLY_W = 8,
  parameter int DIV_W = 12
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // configuration
  input wire logic [DIV_W-1:0] clkDiv,
  input wire logic [ssk_pkg::SEL_W-1:0] txStartSel,
  input wire logic [DLY_W-1:0] txStartDelay,
  input wire logic [ssk_pkg::SEL_W-1:0] txFsOutSel,
  input wire logic txClkIsOutput,
  input wire logic [1:0] rxClkSource,
  input wire logic [1:0] rxClkOutMode,
  input wire logic rxClkInvert,
  // observed outputs
  input wire logic txDataOe_q,
  input wire logic txDone_q,
  input wire logic txReject_q,
  input wire logic rxClkOut_q,
  input wire logic rxClkOe_q,
  input wire logic rxValid_q
);
  import ssk_pkg::*;
  logic bad;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  assign bad = txClkIsOutput && txFsOutSel == FS_NONE && txStartDelay == '0 &&
    (txStartSel == START_FALL || txStartSel == START_RISE || txStartSel == START_ANY);
  a_reject_level: assert property (!$past(rst) && $stable(bad) |-> txReject_q == bad)
    else $error("reject level wrong");
  a_reject_hold: assert property (txReject_q && $past(txReject_q) && !$past(txDataOe_q) |-> !txDataOe_q)
    else $error("refused config sent data");
  a_xfer_release: assert property (rxValid_q && rxClkOutMode == CKO_XFER |-> !rxClkOe_q)
    else $error("rx clock still driven");
  a_first_half: assert property ($rose(rxClkOe_q) && rxClkOutMode == CKO_XFER && rxClkSource == CKS_DIV &&
    !rxClkInvert && clkDiv == 2 |-> !rxClkOut_q [*3] ##1 rxClkOut_q [*3] ##1 !rxClkOut_q)
    else $error("first rx clock cycle wrong");
  a_oe_done: assert property ($fell(txDataOe_q) |-> txDone_q)
    else $error("data release without done");
  a_done_pulse: assert property (txDone_q |=> !txDone_q)
    else $error("done not a pulse");
  a_valid_pulse: assert property (rxValid_q |=> !rxValid_q)
    else $error("valid not a pulse");
  a_cont_restart: assert property (txDone_q && txStartSel == START_CONT && txStartDelay == '0 && !txReject_q
    |-> ##[1:2] txDataOe_q)
    else $error("zero delay restart late");
endmodule : ssk_start_clocking_checker
bind ssk_start_clocking ssk_start_clocking_checker #(.DLY_W(DLY_W), .DIV_W(DIV_W)) i_chk (.ref_clk, .rst,
  .clkDiv, .txStartSel, .txStartDelay, .txFsOutSel, .txClkIsOutput, .rxClkSource, .rxClkOutMode,
  .rxClkInvert, .txDataOe_q, .txDone_q, .txReject_q, .rxClkOut_q, .rxClkOe_q, .rxValid_q);

/* test/ssk_serial_peer.sv */
// external serial peer sending receive frames
`timescale 1ns/1ps
module ssk_serial_peer (
  // clock and request
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [7:0] word,
  // serial pins
  input wire logic rxClkPin,
  output logic rxFsIn,
  output logic rxDataIn,
  output logic busy
);
  logic [7:0] sh;
  logic [3:0] n;
  logic pinP;
  logic pend;
  logic last;
  initial begin
    rxFsIn = 1'b0;
    rxDataIn = 1'b0;
    busy = 1'b0;
    pinP = 1'b1;
    pend = 1'b0;
    last = 1'b0;
    n = 4'h0;
    sh = 8'h0;
  end
  always @(negedge ref_clk) begin
    pinP <= rxClkPin;
    pend <= busy && pinP && !rxClkPin;
    last <= busy && (n == 4'h8) && !pinP && rxClkPin;
    if (go && !busy) begin
      busy <= 1'b1;
      sh <= word;
      n <= 4'h0;
      rxFsIn <= 1'b1;
    end else if (pend && n != 4'h8) begin
      // each pin fall presents the next bit, msb first
      n <= n + 4'h1;
      rxDataIn <= sh[7];
      sh <= sh << 1;
    end else if (last) begin
      // release one cycle after the rise that follows the last bit
      busy <= 1'b0;
      rxFsIn <= 1'b0;
      rxDataIn <= ~rxDataIn;
    end
  end
endmodule : ssk_serial_peer

/* test/test_ssk_start_clocking.sv */
// self-checking bench for the serial start and clocking logic
`timescale 1ns/1ps
module test_ssk_start_clocking;
  import ssk_pkg::*;
  localparam logic [5:0] TGT = 6'h3a;
  logic ref_clk, rst, txClkIsOutput, rxClkInvert, tfDrv, go, pBusy, txClkP, fs0;
  logic [11:0] clkDiv;
  logic [7:0] txStartDelay, txWord, w, txSh, rxWord_q;
  logic [2:0] txStartSel, txFsOutSel, rxStartSel, rxFsOutSel;
  logic [1:0] txClkSource, rxClkSource, rxClkOutMode;
  logic txClkOut_q, txClkOe_q, txFsOut_q, txFsOe_q, txDataOut_q, txDataOe_q, rxClkOut_q, rxClkOe_q;
  logic txDone_q, txReject_q, rxValid_q, rxFsIn, rxDataIn;
  logic [7:0] expTx[$];
  logic [7:0] expRx[$];
  int miscompares = 0;
  int compares = 0;
  wire rxClkPin = rxClkOe_q ? rxClkOut_q : 1'b1;
  wire txFsPin = txFsOe_q ? txFsOut_q : tfDrv;
  ssk_start_clocking i_dut (.ref_clk, .rst, .clkDiv, .txStartSel, .txStartDelay, .txFsOutSel, .txClkSource,
    .txClkIsOutput, .txWord, .rxStartSel, .rxFsOutSel, .rxClkSource, .rxClkOutMode, .rxClkInvert,
    .txClkIn(1'b0), .txClkOut_q, .txClkOe_q, .txFsIn(txFsPin), .txFsOut_q, .txFsOe_q, .txDataOut_q,
    .txDataOe_q, .rxClkIn(rxClkPin), .rxClkOut_q, .rxClkOe_q, .rxFsIn, .rxDataIn, .txDone_q, .txReject_q,
    .rxWord_q, .rxValid_q);
  ssk_serial_peer i_peer (.ref_clk, .go, .word(w), .rxClkPin, .rxFsIn, .rxDataIn, .busy(pBusy));
  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic cfg(logic [2:0] ts, logic [7:0] dl, logic [2:0] fo, logic co, logic [2:0] rs, logic [1:0] rm);
    txStartSel = ts;
    txStartDelay = dl;
    txFsOutSel = fo;
    txClkIsOutput = co;
    rxStartSel = rs;
    rxClkOutMode = rm;
  endtask : cfg
  task automatic run_word(int n);
    for (int j = 0; j < n; j++) begin
      @(negedge ref_clk);
      for (int k = 0; k < 300 && txDone_q !== 1'b1; k++) @(negedge ref_clk);
    end
    cfg(START_RX, txStartDelay, FS_NONE, txClkIsOutput, START_RX, CKO_CONT);
  endtask : run_word
  // monitor: bits taken at tx clock rise
  always @(posedge ref_clk) begin
    txClkP <= txClkOut_q;
    if (txDataOe_q === 1'b1 && txClkOut_q === 1'b1 && txClkP === 1'b0) txSh <= {txSh[6:0], txDataOut_q};
    if (txDone_q === 1'b1 && txClkOe_q === 1'b1 && expTx.size() > 0) check("txWord", txSh, expTx.pop_front());
    if (rxValid_q === 1'b1 && expRx.size() > 0) check("rxWord", rxWord_q, expRx.pop_front());
  end
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    #3000000;
    miscompares++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    clkDiv = 12'h2;
    txClkSource = CKS_DIV;
    rxClkSource = CKS_DIV;
    rxClkInvert = 1'b0;
    rxFsOutSel = FS_NONE;
    tfDrv = 1'b0;
    go = 1'b0;
    w = 8'h0;
    txWord = 8'h0;
    cfg(START_RX, 8'h1, FS_NONE, 1'b0, START_RX, CKO_CONT);
    void'($urandom(32'hc7ec));
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    for (int i = 0; i < 2; i++) begin
      txWord = 8'($urandom);
      if (i == 0) expTx.push_back(txWord);
      cfg(START_CONT, 8'(1 - i), FS_NONE, 1'(1 - i), START_RX, CKO_CONT);
      run_word(2);
    end
    $display("test continuous transmit done");
    for (int c = 2; c < 8; c++) begin
      tfDrv = ~TGT[c-2];
      repeat (2) @(negedge ref_clk);
      cfg(3'(c), 8'h0, FS_NONE, 1'b1, START_RX, CKO_CONT);
      repeat (2) @(negedge ref_clk);
      check("txReject", {7'h0, txReject_q}, {7'h0, c == 4 || c == 5 || c == 7});
      if (c == 4 || c == 5 || c == 7) begin
        repeat (2) begin
          tfDrv = ~tfDrv;
          repeat (2) @(negedge ref_clk);
        end
        check("txDataOe", {7'h0, txDataOe_q}, 8'h0);
      end
      txWord = 8'($urandom);
      expTx.push_back(txWord);
      cfg(3'(c), 8'h1, FS_NONE, 1'b1, START_RX, CKO_CONT);
      repeat (2) @(negedge ref_clk);
      tfDrv = TGT[c-2];
      run_word(1);
    end
    $display("test start selection done");
    cfg(START_RX, 8'h1, FS_TOGGLE, 1'b0, START_RISE, CKO_XFER);
    repeat (3) @(negedge ref_clk);
    for (int i = 0; i < 2; i++) begin
      w = 8'($urandom);
      expRx.push_back(w);
      fs0 = txFsOut_q;
      go <= 1'b1;
      for (int k = 0; k < 50 && pBusy !== 1'b1; k++) @(negedge ref_clk);
      go <= 1'b0;
      for (int k = 0; k < 300 && rxValid_q !== 1'b1; k++) @(negedge ref_clk);
      if (i == 0) check("txFsOut", {7'h0, txFsOut_q}, {7'h0, ~fs0});
      repeat (4) @(negedge ref_clk);
    end
    $display("test receive frame done");
    check("pending", 8'(expTx.size() + expRx.size()), 8'h0);
    end_sim();
  end
endmodule : test_ssk_start_clocking
